// ### include/pinmux_pkg.sv
package pinmux_pkg;

  // Register bus geometry
  localparam int ADDR_W = 4;
  localparam int DATA_W = 16;

  // Register offsets
  localparam logic [3:0] OFF_GLOBAL_CTRL_ONE = 4'h0;
  localparam logic [3:0] OFF_GP_IO = 4'h1;
  localparam logic [3:0] OFF_STATUS = 4'h2;

  // Clock output control field in the global control register
  localparam int CKMODE_LSB = 0;
  localparam logic [1:0] CKMODE_RUN = 2'h0;
  localparam logic [1:0] CKMODE_LOW = 2'h1;
  localparam logic [1:0] CKMODE_HIZ = 2'h2;
  localparam logic [1:0] CKMODE_RST = CKMODE_RUN;

  // Shared line register fields
  localparam int GP_DIR_BIT = 0;
  localparam int GP_OUT_BIT = 1;
  localparam logic GP_DIR_RST = 1'b0;
  localparam logic GP_OUT_RST = 1'b0;

  // Status register fields
  localparam int ST_GP_IN_BIT = 0;
  localparam int ST_STRAP_BIT = 1;
  localparam int ST_CLKSEL_BIT = 2;
  localparam int ST_HOLD_BIT = 3;
  localparam int ST_CFG_BIT = 4;
  localparam int ST_EDGE_LSB = 8;
  localparam int EDGE_W = 8;

  // Cycles after reset release before straps are taken
  localparam int SYNC_STAGES = 2;
  localparam logic [1:0] CAPTURE_CYC = 2'(SYNC_STAGES + 1);

  // Bus hold handshake states
  typedef enum logic [1:0] {
    HS_BOOT,
    HS_ACTIVE,
    HS_RELEASE,
    HS_HOLD
  } hold_st_e;

endpackage : pinmux_pkg

// ### src/pin_sync.sv
`timescale 1ns/1ps
module pin_sync #(
  parameter int W = 1
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Asynchronous inputs and their synchronised copies
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);

  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
  } sync_s;

  sync_s st_ff;
  sync_s nxt_st;

  // Stage one feeds stage two only
  always_comb
  begin
    nxt_st = st_ff;
    nxt_st.s1 = d;
    nxt_st.s2 = st_ff.s1;
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      st_ff <= '0;
    else
      st_ff <= nxt_st;
  end

  assign q = st_ff.s2;

endmodule : pin_sync

// ### src/extmem_pin_config.sv
// The implementer's own choices: strobed register access and the register offsets.
`timescale 1ns/1ps
// Notes on behaviour
// - A low boot strap gives the shared pin its general-purpose I/O role.
// - In I/O role the shared line comes up as an input, driving nothing.
// - A high boot strap gives the shared pin its hold-acknowledge role.
// - Hold-acknowledge floats in reset and until pin roles are fixed, then drives 1.
// - Hold-acknowledge is asserted only in hold, with the bus floated.
// - Pin roles are fixed on the fourth clock after reset is released.
// - A high clock-source select clocks the interface from the clock pin.
// - A low clock-source select clocks it from system clock three.
// - Clock output one carries the interface clock unless set low or off.
// - Clock output one floats for the whole of reset.
// - Strap 0 with select 0 leaves clock output one floating.
// - Strap 0 with select 1 toggles clock output one at the pin clock.
// - Strap 1 with select 0 toggles it at system clock three.
// - Strap 1 with select 1 toggles it at the pin clock.
module extmem_pin_config #(
  parameter int AW = pinmux_pkg::ADDR_W,
  parameter int DW = pinmux_pkg::DATA_W
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Straps and clock pins
  input wire logic boot_function_strap,
  input wire logic ext_mem_clock_source_sel,
  input wire logic ext_mem_clock_in,
  input wire logic system_clock_three,
  // Hold handshake
  input wire logic hold_req_n,
  output logic mem_bus_oe,
  // Shared pin
  input wire logic shared_gp_io_line_in,
  output logic shared_gp_io_line_out,
  output logic shared_gp_io_line_oe,
  // Clock output one
  output logic ext_mem_clock_out_one,
  output logic ext_mem_clock_out_one_oe,
  // Register port
  input wire logic [AW-1:0] reg_addr,
  input wire logic [DW-1:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [DW-1:0] reg_rdata
);

  // Status packs edge count up to bit 15
  if (DW < pinmux_pkg::ST_EDGE_LSB + pinmux_pkg::EDGE_W)
  begin : g_bad_dw
    $error("Data width too small for status register");
  end
  if (AW < 2)
  begin : g_bad_aw
    $error("Address width too small for register map");
  end

  typedef struct packed {
    pinmux_pkg::hold_st_e st;
    logic [1:0] boot_cnt;
    logic cfg_done;
    logic hold_mode;
    logic strap_seen;
    logic [1:0] ck_mode;
    logic gp_dir;
    logic gp_out;
    logic ck_out;
    logic ck_prev;
    logic [pinmux_pkg::EDGE_W-1:0] edge_cnt;
    logic bus_oe;
    logic hold_ack_n;
    logic [DW-1:0] rdata;
  } cfg_s;

  cfg_s st_ff;
  cfg_s nxt_st;

  logic strap_s;
  logic sel_s;
  logic eclk_s;
  logic sys_s;
  logic req_n_s;
  logic gp_in_s;
  logic src_clk;
  logic wr_ctrl;
  logic wr_gp;
  logic [DW-1:0] rd_val;

  // Every pin passes two flops before use
  pin_sync #(
    .W(6)
  ) u_sync (
    .clk(clk),
    .rst_n(rst_n),
    .d({boot_function_strap, ext_mem_clock_source_sel, ext_mem_clock_in,
        system_clock_three, hold_req_n, shared_gp_io_line_in}),
    .q({strap_s, sel_s, eclk_s, sys_s, req_n_s, gp_in_s})
  );

  // Interface clock choice follows the select pin live
  assign src_clk = sel_s ? eclk_s : sys_s;

  assign wr_ctrl = reg_wr && (reg_addr == AW'(pinmux_pkg::OFF_GLOBAL_CTRL_ONE));
  assign wr_gp = reg_wr && (reg_addr == AW'(pinmux_pkg::OFF_GP_IO));

  // Read mux; unmapped offsets answer zero
  always_comb
  begin
    rd_val = '0;
    case (reg_addr)
      AW'(pinmux_pkg::OFF_GLOBAL_CTRL_ONE):
        rd_val[pinmux_pkg::CKMODE_LSB +: 2] = st_ff.ck_mode;
      AW'(pinmux_pkg::OFF_GP_IO):
      begin
        rd_val[pinmux_pkg::GP_DIR_BIT] = st_ff.gp_dir;
        rd_val[pinmux_pkg::GP_OUT_BIT] = st_ff.gp_out;
      end
      AW'(pinmux_pkg::OFF_STATUS):
      begin
        rd_val[pinmux_pkg::ST_GP_IN_BIT] = gp_in_s;
        rd_val[pinmux_pkg::ST_STRAP_BIT] = st_ff.strap_seen;
        rd_val[pinmux_pkg::ST_CLKSEL_BIT] = sel_s;
        rd_val[pinmux_pkg::ST_HOLD_BIT] = !st_ff.hold_ack_n;
        rd_val[pinmux_pkg::ST_CFG_BIT] = st_ff.cfg_done;
        rd_val[pinmux_pkg::ST_EDGE_LSB +: pinmux_pkg::EDGE_W] =
          st_ff.edge_cnt;
      end
      default: rd_val = '0;
    endcase
  end

  // Next-state logic for the whole block
  always_comb
  begin
    nxt_st = st_ff;
    // Read data stands only in the cycle after the strobe
    nxt_st.rdata = reg_rd ? rd_val : '0;
    if (wr_ctrl)
      nxt_st.ck_mode = reg_wdata[pinmux_pkg::CKMODE_LSB +: 2];
    if (wr_gp)
    begin
      nxt_st.gp_dir = reg_wdata[pinmux_pkg::GP_DIR_BIT];
      nxt_st.gp_out = reg_wdata[pinmux_pkg::GP_OUT_BIT];
    end
    // Edge counter shows the chosen clock is alive
    nxt_st.ck_prev = src_clk;
    if (src_clk && !st_ff.ck_prev)
    begin
      nxt_st.edge_cnt = st_ff.edge_cnt + 1'b1;
    end
    // Clock out is a resampled copy; low when held low
    nxt_st.ck_out = (st_ff.ck_mode == pinmux_pkg::CKMODE_RUN) &&
                    src_clk;
    case (st_ff.st)
      pinmux_pkg::HS_BOOT:
      begin
        // Wait for synchronisers to carry post-reset pin levels
        nxt_st.boot_cnt = st_ff.boot_cnt + 1'b1;
        if (st_ff.boot_cnt == pinmux_pkg::CAPTURE_CYC)
        begin
          nxt_st.boot_cnt = st_ff.boot_cnt;
          nxt_st.cfg_done = 1'b1;
          nxt_st.hold_mode = strap_s;
          nxt_st.strap_seen = strap_s;
          nxt_st.hold_ack_n = 1'b1;
          nxt_st.bus_oe = 1'b1;
          if (!strap_s && !sel_s)
          begin
            nxt_st.ck_mode = pinmux_pkg::CKMODE_HIZ;
          end
          else
          begin
            nxt_st.ck_mode = pinmux_pkg::CKMODE_RUN;
          end
          nxt_st.st = pinmux_pkg::HS_ACTIVE;
        end
      end
      pinmux_pkg::HS_ACTIVE:
      begin
        // Request only honoured when the pin is hold-acknowledge
        if (st_ff.hold_mode && !req_n_s)
        begin
          nxt_st.bus_oe = 1'b0;
          nxt_st.st = pinmux_pkg::HS_RELEASE;
        end
      end
      pinmux_pkg::HS_RELEASE:
      begin
        // Bus floated a cycle before the acknowledge goes out
        nxt_st.hold_ack_n = 1'b0;
        nxt_st.st = pinmux_pkg::HS_HOLD;
      end
      pinmux_pkg::HS_HOLD:
      begin
        if (req_n_s)
        begin
          nxt_st.hold_ack_n = 1'b1;
          nxt_st.bus_oe = 1'b1;
          nxt_st.st = pinmux_pkg::HS_ACTIVE;
        end
      end
      default:
      begin
        nxt_st.st = pinmux_pkg::HS_BOOT;
      end
    endcase
  end

  // Reset floats every pin and clears all control
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      st_ff <= '0;
      st_ff.st <= pinmux_pkg::HS_BOOT;
      st_ff.ck_mode <= pinmux_pkg::CKMODE_RST;
      st_ff.gp_dir <= pinmux_pkg::GP_DIR_RST;
      st_ff.gp_out <= pinmux_pkg::GP_OUT_RST;
      st_ff.hold_ack_n <= 1'b1;
    end
    else
    begin
      st_ff <= nxt_st;
    end
  end

  // Shared pin: drive only after roles are fixed
  assign shared_gp_io_line_oe = st_ff.cfg_done &&
                                (st_ff.hold_mode || st_ff.gp_dir);
  assign shared_gp_io_line_out = st_ff.hold_mode ? st_ff.hold_ack_n :
                                 st_ff.gp_out;
  assign mem_bus_oe = st_ff.bus_oe;
  assign ext_mem_clock_out_one = st_ff.ck_out;
  assign ext_mem_clock_out_one_oe = st_ff.cfg_done &&
    (st_ff.ck_mode != pinmux_pkg::CKMODE_HIZ);
  assign reg_rdata = st_ff.rdata;

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);

  AST_GP_ROLE: assert property (
    st_ff.cfg_done && !st_ff.hold_mode |->
      shared_gp_io_line_oe == st_ff.gp_dir &&
      shared_gp_io_line_out == st_ff.gp_out)
    else $error("Shared line does not follow I/O registers");

  AST_GP_INPUT_AT_START: assert property (
    $rose(st_ff.cfg_done) && !st_ff.hold_mode |-> !shared_gp_io_line_oe)
    else $error("Shared line driven at end of reset");

  AST_HOLDA_ROLE: assert property (
    st_ff.cfg_done && st_ff.hold_mode |->
      shared_gp_io_line_oe && shared_gp_io_line_out == st_ff.hold_ack_n)
    else $error("Shared line not acting as hold acknowledge");

  AST_HOLDA_START_HIGH: assert property (
    $rose(st_ff.cfg_done) && st_ff.hold_mode |->
      shared_gp_io_line_oe && shared_gp_io_line_out)
    else $error("Hold acknowledge not high after reset");

  AST_BOOT_FLOAT: assert property (
    !st_ff.cfg_done |-> !shared_gp_io_line_oe && !mem_bus_oe)
    else $error("Pins driven before roles fixed");

  AST_HOLD_BUS_FLOAT: assert property (
    !st_ff.hold_ack_n |-> !mem_bus_oe && !$past(mem_bus_oe))
    else $error("Hold acknowledged while bus driven");

  AST_HOLD_ENTRY: assert property (
    st_ff.st == pinmux_pkg::HS_ACTIVE && st_ff.hold_mode && !req_n_s |=>
      !mem_bus_oe ##1 !st_ff.hold_ack_n)
    else $error("Hold entry sequence wrong");

  AST_STRAP_CAPTURE: assert property (
    $rose(st_ff.cfg_done) |-> st_ff.hold_mode == $past(strap_s))
    else $error("Strap not captured at release");

  AST_CLK_FROM_PIN: assert property (
    st_ff.ck_mode == pinmux_pkg::CKMODE_RUN && sel_s |=>
      ext_mem_clock_out_one == $past(eclk_s))
    else $error("Clock output not following clock pin");

  AST_CLK_FROM_SYS: assert property (
    st_ff.ck_mode == pinmux_pkg::CKMODE_RUN && !sel_s |=>
      ext_mem_clock_out_one == $past(sys_s))
    else $error("Clock output not following system clock three");

  AST_CLK_HELD_LOW: assert property (
    st_ff.cfg_done && st_ff.ck_mode == pinmux_pkg::CKMODE_LOW |->
      ext_mem_clock_out_one_oe ##1 !ext_mem_clock_out_one)
    else $error("Clock output not held low");

  AST_CLK_FLOAT_BOOT: assert property (
    !st_ff.cfg_done |-> !ext_mem_clock_out_one_oe)
    else $error("Clock output driven during reset");

  AST_CLK_STRAP00: assert property (
    $rose(st_ff.cfg_done) && !$past(strap_s) && !$past(sel_s) |->
      !ext_mem_clock_out_one_oe)
    else $error("Clock output driven with both straps low");

  AST_CLK_STRAP_RUN: assert property (
    $rose(st_ff.cfg_done) && ($past(strap_s) || $past(sel_s)) |->
      ext_mem_clock_out_one_oe)
    else $error("Clock output not running after reset");

  AST_HOLD_EXIT: assert property (
    $rose(st_ff.hold_ack_n) |-> $past(req_n_s) && mem_bus_oe)
    else $error("Hold left while request still asserted");

  COV_HOLD: cover property (
    !req_n_s ##1 !st_ff.hold_ack_n [*3] ##1 st_ff.hold_ack_n);
  COV_GP_OUT: cover property (
    st_ff.cfg_done && !st_ff.hold_mode && shared_gp_io_line_oe);
  COV_CLK_TOGGLE: cover property (
    ext_mem_clock_out_one_oe && $rose(ext_mem_clock_out_one));
  COV_READ: cover property (reg_rd ##1 reg_rdata != '0);

endmodule : extmem_pin_config

// ### verif/ext_mem_partner.sv
`timescale 1ns/1ps
// Far side: memory clock pin, clock three and an outside bus master
module ext_mem_partner (
  // Bench clock
  input wire logic clk,
  // Master wants the memory bus
  input wire logic want_bus,
  // Pins toward the block
  output logic ext_mem_clock_in,
  output logic system_clock_three,
  output logic hold_req_n
);
  // Free-running clocks, offset so they never race clk
  initial
  begin
    ext_mem_clock_in = 1'b0;
    #7;
    forever #100 ext_mem_clock_in = ~ext_mem_clock_in;
  end
  initial
  begin
    system_clock_three = 1'b0;
    #3;
    forever #50 system_clock_three = ~system_clock_three;
  end
  // Request held low for as long as the master wants the bus
  initial hold_req_n = 1'b1;
  always @(posedge clk) hold_req_n <= ~want_bus;
endmodule : ext_mem_partner

// ### verif/test_extmem_pin_config.sv
`timescale 1ns/1ps
module test_extmem_pin_config;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic boot_function_strap = 1'b0;
  logic ext_mem_clock_source_sel = 1'b0;
  logic want_bus = 1'b0;
  logic pin_ext = 1'b0;
  logic [3:0] reg_addr = 4'h0;
  logic [15:0] reg_wdata = 16'h0;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [15:0] reg_rdata;
  logic [15:0] rd_val;
  logic ext_mem_clock_in, system_clock_three, hold_req_n, mem_bus_oe;
  logic shared_gp_io_line_in, shared_gp_io_line_out, shared_gp_io_line_oe;
  logic ext_mem_clock_out_one, ext_mem_clock_out_one_oe;
  int n_fail = 0;
  int checks = 0;

  // Pin level: the block wins while it drives
  assign shared_gp_io_line_in =
    shared_gp_io_line_oe ? shared_gp_io_line_out : pin_ext;

  // 40 MHz clock
  always #12.5 clk = ~clk;

  extmem_pin_config i_dut (.clk, .rst_n, .boot_function_strap,
    .ext_mem_clock_source_sel, .ext_mem_clock_in, .system_clock_three,
    .hold_req_n, .mem_bus_oe, .shared_gp_io_line_in,
    .shared_gp_io_line_out, .shared_gp_io_line_oe, .ext_mem_clock_out_one,
    .ext_mem_clock_out_one_oe, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
    .reg_rdata);

  ext_mem_partner i_far (.clk, .want_bus, .ext_mem_clock_in,
    .system_clock_three, .hold_req_n);

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    checks++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("BAD t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic finish_test;
    $display("comparisons %0d mismatches %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : finish_test

  // Let n edges pass, then sample settled outputs
  task automatic idle(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : idle

  task automatic wr_reg(input logic [3:0] a, input logic [15:0] d);
    @(posedge clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask : wr_reg

  // Read data stand only in the cycle after the strobe
  task automatic rd_reg(input logic [3:0] a);
    @(posedge clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1;
    rd_val = reg_rdata;
  endtask : rd_reg

  task automatic do_reset(input logic s, input logic c);
    @(posedge clk);
    rst_n <= 1'b0;
    boot_function_strap <= s;
    ext_mem_clock_source_sel <= c;
    idle(7);
    check(16'(ext_mem_clock_out_one_oe), 16'h0);
    check(16'(shared_gp_io_line_oe), 16'h0);
    @(posedge clk);
    rst_n <= 1'b1;
    idle(6);
  endtask : do_reset

  // Rising edges of clock output one over 80 cycles
  task automatic count_edges(output logic [15:0] n);
    logic last;
    n = 16'h0;
    last = ext_mem_clock_out_one;
    repeat (80)
    begin
      idle(1);
      if (ext_mem_clock_out_one && !last)
        n++;
      last = ext_mem_clock_out_one;
    end
  endtask : count_edges

  // Pin clock 8 cycles a period, clock three 4
  function automatic logic [15:0] exp_edges(input logic c);
    return c ? 16'h000a : 16'h0014;
  endfunction : exp_edges

  // Main sequence
  initial
  begin
    logic s, c, b;
    logic [15:0] n;
    void'($urandom(4748));
    for (int k = 0; k < 4; k++)
    begin
      s = k[1];
      c = k[0];
      do_reset(s, c);
      check(16'(shared_gp_io_line_oe), 16'(s));
      check(16'(shared_gp_io_line_out & s), 16'(s));
      check(16'(ext_mem_clock_out_one_oe), 16'(s | c));
      @(posedge clk);
      pin_ext <= 1'($urandom);
      idle(1);
      count_edges(n);
      if (s | c)
        check(n, exp_edges(c));
      @(posedge clk);
      boot_function_strap <= ~s;
      rd_reg(pinmux_pkg::OFF_STATUS);
      check(16'(rd_val[pinmux_pkg::ST_STRAP_BIT]), 16'(s));
      check(16'(rd_val[pinmux_pkg::ST_GP_IN_BIT]), 16'(s | pin_ext));
      @(posedge clk);
      ext_mem_clock_source_sel <= ~c;
      idle(6);
      count_edges(n);
      if (s | c)
        check(n, exp_edges(~c));
      $display("strap %0d select %0d done", s, c);
    end
    // Clock output modes, pin clock selected
    @(posedge clk);
    ext_mem_clock_source_sel <= 1'b1;
    wr_reg(pinmux_pkg::OFF_GLOBAL_CTRL_ONE, 16'(pinmux_pkg::CKMODE_LOW));
    idle(6);
    check(16'({ext_mem_clock_out_one, ext_mem_clock_out_one_oe}), 16'h1);
    wr_reg(pinmux_pkg::OFF_GLOBAL_CTRL_ONE, 16'(pinmux_pkg::CKMODE_HIZ));
    idle(3);
    check(16'(ext_mem_clock_out_one_oe), 16'h0);
    wr_reg(pinmux_pkg::OFF_GLOBAL_CTRL_ONE, 16'(pinmux_pkg::CKMODE_RUN));
    rd_reg(pinmux_pkg::OFF_GLOBAL_CTRL_ONE);
    check(rd_val, 16'(pinmux_pkg::CKMODE_RUN));
    count_edges(n);
    check(n, exp_edges(1'b1));
    rd_reg(4'hf);
    check(rd_val, 16'h0);
    $display("clock modes done");
    // Hold handshake in acknowledge role
    check(16'(mem_bus_oe), 16'h1);
    want_bus <= 1'b1;
    repeat (30)
      if (shared_gp_io_line_out !== 1'b0)
        idle(1);
    check(16'({shared_gp_io_line_out, mem_bus_oe}), 16'h0);
    rd_reg(pinmux_pkg::OFF_STATUS);
    check(16'(rd_val[pinmux_pkg::ST_HOLD_BIT]), 16'h1);
    idle(20);
    check(16'({shared_gp_io_line_out, mem_bus_oe}), 16'h0);
    want_bus <= 1'b0;
    repeat (30)
      if (shared_gp_io_line_out !== 1'b1)
        idle(1);
    check(16'({shared_gp_io_line_out, mem_bus_oe}), 16'h3);
    $display("hold handshake done");
    // I/O role: request ignored, line driven on demand
    do_reset(1'b0, 1'($urandom));
    want_bus <= 1'b1;
    idle(10);
    check(16'(shared_gp_io_line_oe), 16'h0);
    b = 1'($urandom);
    wr_reg(pinmux_pkg::OFF_GP_IO, {14'h0, b, 1'b1});
    idle(3);
    check(16'({shared_gp_io_line_oe, shared_gp_io_line_out}), {15'h1, b});
    want_bus <= 1'b0;
    $display("shared line done");
    finish_test();
  end

  // Watchdog: ten thousand cycles, ten times what the tests need
  initial
  begin
    #250000;
    n_fail++;
    finish_test();
  end
endmodule : test_extmem_pin_config
